// ---- rtl/ssis_pkg.sv ----
// Constants and types shared by the speed sensor input stage.
// Assumes a single peripheral clock domain and an 8-bit register port.
package ssis_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int PIN_N = 3;

	// Register addresses
	localparam logic [3:0] CFG_ADDR = 4'h0;
	localparam logic [3:0] PRE_ADDR = 4'h1;
	localparam logic [3:0] STAT_ADDR = 4'h2;
	localparam logic [3:0] LVL_ADDR = 4'h3;

	// Configuration register field positions
	localparam int TES_LSB = 0;
	localparam int IS_LSB = 2;
	localparam int PCN_BIT = 4;
	localparam int SR_BIT = 5;
	localparam int OFFSEL_BIT = 6;
	localparam int DAC_BIT = 7;

	// Status register field positions
	localparam int ST_DIR = 0;
	localparam int ST_SPEED = 1;
	localparam int ST_ENC = 2;
	localparam int ST_COMP = 3;

	// Reset values
	localparam logic [1:0] TES_RST = 2'h0;
	localparam logic [1:0] IS_RST = 2'h0;
	localparam logic [2:0] PIN_RST = 3'h0;

	// Tacho edge field codes
	localparam logic [1:0] TES_NONE = 2'h0;
	localparam logic [1:0] TES_RISE = 2'h1;
	localparam logic [1:0] TES_FALL = 2'h2;
	localparam logic [1:0] TES_BOTH = 2'h3;

	// Input select code for the quadrature encoder
	localparam logic [1:0] IS_ENC = 2'h3;

	typedef enum logic [1:0]
	{
		PIN_IO = 2'b00,
		PIN_ANA = 2'b01,
		PIN_DIG = 2'b10,
		PIN_OFF = 2'b11
	} ssis_pin_type;

endpackage

// ---- rtl/ssis_sync.sv ----
// Two-stage synchroniser for the three sensor pins.
// Assumes the pins are asynchronous to clk.
`timescale 1ns/1ps
module ssis_sync
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [ssis_pkg::PIN_N-1:0] din,
	output logic [ssis_pkg::PIN_N-1:0] dout
);

	logic [ssis_pkg::PIN_N-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_r <= ssis_pkg::PIN_RST;
			dout <= ssis_pkg::PIN_RST;
		end
		else
		begin
			meta_r <= din;
			dout <= meta_r;
		end
	end

endmodule

// ---- rtl/ssis_top.sv ----
// Speed sensor input stage: tacho capture, encoder clock and direction,
// and the function assignment of the three sensor pins.
// Assumes a plain register port and a one-cycle commutation pulse on clk.
//
// What this block does
// - Nonzero edge field selects speed sensor mode
// - Select 00-10 tacho pin, 11 encoder
// - Chosen pin to edge detector, others free
// - Edge field picks rising, falling or both
// - Input select preloaded; direct access applies immediately
// - Encoder uses all edges, four times clock
// - Direction flag read only, counts unaffected
// - Direction samples A on B falling edge
// - Single encoder input gives half-rate clock
// - Sensor mode: selected pin analog, others ports
// - Sensorless: controller owns pins, off-state per bit
// - Release with encoder select frees all pins when the edge field is zero
// - Speed mode: selected pins digital, comparator off
// - Analog pin has digital input path disabled
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module ssis_top
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	input wire logic commutation_evt,
	input wire logic sensor_input_a,
	input wire logic sensor_input_b,
	input wire logic sensor_input_c,
	output logic capture_evt,
	output logic encoder_clk,
	output logic encoder_direction_flag,
	output logic phase_comp_on,
	output logic [1:0] pin_mode_a,
	output logic [1:0] pin_mode_b,
	output logic [1:0] pin_mode_c,
	output logic [2:0] pin_ground,
	output logic [2:0] dig_in_en
);

	logic [1:0] tacho_edge_field_r;
	logic [1:0] input_select_field_r;
	logic [1:0] input_select_pre_r;
	logic pin_release_bit_r;
	logic sensor_used_bit_r;
	logic off_state_select_bit_r;
	logic direct_access_r;
	logic [2:0] pin_s;
	logic [2:0] pin_prev_r;
	logic [2:0] rise;
	logic [2:0] fall;
	logic speed_mode;
	logic enc_mode;
	logic cfg_wr;
	logic pre_wr;
	logic capture_r;
	logic enc_clk_r;
	logic dir_r;
	logic comp_r;
	logic [1:0] pmode_r [3];
	logic [2:0] gnd_r;
	logic [2:0] dig_r;
	logic [7:0] rdata_r;

	// Role of one pin from the current configuration
	function automatic ssis_pkg::ssis_pin_type pin_role
	(
		input logic [1:0] tes,
		input logic [1:0] sel,
		input logic pin_release_bit,
		input logic sr,
		input int idx
	);
		ssis_pkg::ssis_pin_type role;
		role = ssis_pkg::PIN_IO;
		if (tes != ssis_pkg::TES_NONE)
		begin
			if (sel == ssis_pkg::IS_ENC)
				role = (idx < 2) ? ssis_pkg::PIN_DIG : ssis_pkg::PIN_IO;
			else
				role = (idx == int'(sel)) ? ssis_pkg::PIN_DIG
					: ssis_pkg::PIN_IO;
		end
		else if (sel == ssis_pkg::IS_ENC)
			role = (pin_release_bit || sr) ? ssis_pkg::PIN_IO : ssis_pkg::PIN_OFF;
		else if (idx == int'(sel))
			role = ssis_pkg::PIN_ANA;
		else
			role = (pin_release_bit || sr) ? ssis_pkg::PIN_IO : ssis_pkg::PIN_OFF;
		return role;
	endfunction

	// Edge filter for the tacho capture event
	function automatic logic edge_hit
	(
		input logic [1:0] tes,
		input logic r,
		input logic f
	);
		logic hit;
		hit = 1'b0;
		unique case (tes)
			ssis_pkg::TES_RISE: hit = r;
			ssis_pkg::TES_FALL: hit = f;
			ssis_pkg::TES_BOTH: hit = r || f;
			ssis_pkg::TES_NONE: hit = 1'b0;
		endcase
		return hit;
	endfunction

	ssis_sync u_sync
	(
		.clk(clk),
		.nrst(nrst),
		.din({sensor_input_c, sensor_input_b, sensor_input_a}),
		.dout(pin_s)
	);

	assign cfg_wr = wr_en && (addr == ssis_pkg::CFG_ADDR);
	assign pre_wr = wr_en && (addr == ssis_pkg::PRE_ADDR);
	assign speed_mode = tacho_edge_field_r != ssis_pkg::TES_NONE;
	assign enc_mode = speed_mode
		&& (input_select_field_r == ssis_pkg::IS_ENC);
	assign rise = pin_s & ~pin_prev_r;
	assign fall = ~pin_s & pin_prev_r;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tacho_edge_field_r <= ssis_pkg::TES_RST;
			pin_release_bit_r <= 1'b0;
			sensor_used_bit_r <= 1'b0;
			off_state_select_bit_r <= 1'b0;
			direct_access_r <= 1'b0;
		end
		else if (cfg_wr)
		begin
			tacho_edge_field_r <= wdata[ssis_pkg::TES_LSB +: 2];
			pin_release_bit_r <= wdata[ssis_pkg::PCN_BIT];
			sensor_used_bit_r <= wdata[ssis_pkg::SR_BIT];
			off_state_select_bit_r <= wdata[ssis_pkg::OFFSEL_BIT];
			direct_access_r <= wdata[ssis_pkg::DAC_BIT];
		end
	end

	// Select writes land in the preload copy
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			input_select_pre_r <= ssis_pkg::IS_RST;
		else if (cfg_wr)
			input_select_pre_r <= wdata[ssis_pkg::IS_LSB +: 2];
		else if (pre_wr)
			input_select_pre_r <= wdata[1:0];
	end

	// Live select moves only at commutation, unless direct access is on;
	// a direct write in the commutation cycle wins as the newer value
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			input_select_field_r <= ssis_pkg::IS_RST;
		else if (cfg_wr && (wdata[ssis_pkg::DAC_BIT] || direct_access_r))
			input_select_field_r <= wdata[ssis_pkg::IS_LSB +: 2];
		else if (pre_wr && direct_access_r)
			input_select_field_r <= wdata[1:0];
		else if (commutation_evt)
			input_select_field_r <= input_select_pre_r;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			pin_prev_r <= ssis_pkg::PIN_RST;
		else
			pin_prev_r <= pin_s;
	end

	// Only the selected pin reaches the edge filter
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			capture_r <= 1'b0;
		else if (speed_mode && !enc_mode)
			capture_r <= edge_hit(tacho_edge_field_r,
				rise[input_select_field_r],
				fall[input_select_field_r]);
		else
			capture_r <= 1'b0;
	end

	// Every edge of A or B clocks; one live input yields half the rate
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			enc_clk_r <= 1'b0;
		else
			enc_clk_r <= enc_mode && ((|rise[1:0]) || (|fall[1:0]));
	end

	// Direction only reported; nothing downstream counts down with it
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			dir_r <= 1'b0;
		else if (enc_mode && fall[1])
			dir_r <= pin_s[0];
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			comp_r <= 1'b0;
		else
			comp_r <= !speed_mode
				&& (input_select_field_r != ssis_pkg::IS_ENC);
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < ssis_pkg::PIN_N; i++)
				pmode_r[i] <= ssis_pkg::PIN_IO;
			gnd_r <= ssis_pkg::PIN_RST;
			dig_r <= ssis_pkg::PIN_RST;
		end
		else
		begin
			for (int i = 0; i < ssis_pkg::PIN_N; i++)
			begin
				pmode_r[i] <= pin_role(tacho_edge_field_r,
					input_select_field_r, pin_release_bit_r,
					sensor_used_bit_r, i);
				gnd_r[i] <= off_state_select_bit_r
					&& (pin_role(tacho_edge_field_r, input_select_field_r,
					pin_release_bit_r, sensor_used_bit_r, i)
					== ssis_pkg::PIN_OFF);
				dig_r[i] <= pin_role(tacho_edge_field_r,
					input_select_field_r, pin_release_bit_r,
					sensor_used_bit_r, i) inside
					{ssis_pkg::PIN_IO, ssis_pkg::PIN_DIG};
			end
		end
	end

	// Read data stand for the one cycle after the strobe
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rdata_r <= 8'h00;
		else if (rd_en)
		begin
			unique case (addr)
				ssis_pkg::CFG_ADDR: rdata_r <= {direct_access_r,
					off_state_select_bit_r, sensor_used_bit_r,
					pin_release_bit_r, input_select_field_r,
					tacho_edge_field_r};
				ssis_pkg::PRE_ADDR: rdata_r <= {6'h00, input_select_pre_r};
				ssis_pkg::STAT_ADDR: rdata_r <= {4'h0, comp_r, enc_mode,
					speed_mode, dir_r};
				ssis_pkg::LVL_ADDR: rdata_r <= {5'h00, pin_s & dig_r};
				default: rdata_r <= 8'h00;
			endcase
		end
		else
			rdata_r <= 8'h00;
	end

	assign rdata = rdata_r;
	assign capture_evt = capture_r;
	assign encoder_clk = enc_clk_r;
	assign encoder_direction_flag = dir_r;
	assign phase_comp_on = comp_r;
	assign pin_mode_a = pmode_r[0];
	assign pin_mode_b = pmode_r[1];
	assign pin_mode_c = pmode_r[2];
	assign pin_ground = gnd_r;
	assign dig_in_en = dig_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_tacho_rise;
		speed_mode && !enc_mode && rise[input_select_field_r];
	endsequence

	sequence s_tacho_fall;
		speed_mode && !enc_mode && fall[input_select_field_r];
	endsequence

	sequence s_b_fall;
		enc_mode && fall[1];
	endsequence

	sync_delay_a: assert property
		(##2 pin_s == $past({sensor_input_c, sensor_input_b,
			sensor_input_a}, 2))
		else $error("sensor pins not delayed two cycles");

	rise_capture_a: assert property
		(s_tacho_rise ##0 (tacho_edge_field_r != ssis_pkg::TES_FALL)
			|=> capture_evt)
		else $error("rising edge capture missed");

	fall_capture_a: assert property
		(s_tacho_fall ##0 (tacho_edge_field_r == ssis_pkg::TES_RISE)
			|=> !capture_evt)
		else $error("falling edge captured in rising mode");

	no_speed_capture_a: assert property
		(!speed_mode |=> !capture_evt && !encoder_clk)
		else $error("event outside speed sensor mode");

	enc_all_edges_a: assert property
		(enc_mode && ((|rise[1:0]) || (|fall[1:0])) |=> encoder_clk)
		else $error("encoder edge lost");

	enc_no_tacho_a: assert property
		(enc_mode |=> !capture_evt)
		else $error("tacho capture in encoder mode");

	dir_sample_a: assert property
		(s_b_fall |=> encoder_direction_flag == $past(pin_s[0]))
		else $error("direction not taken from pin A");

	dir_hold_a: assert property
		(!(enc_mode && fall[1]) |=> $stable(encoder_direction_flag))
		else $error("direction changed without B falling edge");

	preload_hold_a: assert property
		(!commutation_evt && !cfg_wr && !pre_wr
			|=> $stable(input_select_field_r))
		else $error("select changed without commutation or write");

	release_free_a: assert property
		(pin_release_bit_r && speed_mode && enc_mode ##1
			$stable(input_select_field_r) && $stable(tacho_edge_field_r)
			|-> !phase_comp_on && pin_mode_c == ssis_pkg::PIN_IO)
		else $error("release with encoder select not freeing pins");

	analog_path_a: assert property
		(pin_mode_a == ssis_pkg::PIN_ANA |-> !dig_in_en[0])
		else $error("analog pin keeps digital input path");

	sensorless_gnd_a: assert property
		(!pin_release_bit_r && !sensor_used_bit_r && !speed_mode
			&& input_select_field_r == 2'h0 ##1
			$stable(input_select_field_r) && $stable(off_state_select_bit_r)
			&& $stable(pin_release_bit_r) && $stable(sensor_used_bit_r)
			&& $stable(tacho_edge_field_r)
			|-> pin_mode_b == ssis_pkg::PIN_OFF
			&& pin_ground[1] == off_state_select_bit_r)
		else $error("sensorless off-state pin wrong");

endmodule

// ---- test/ssis_sensor_model.sv ----
// Behavioural quadrature encoder with a slower third track on pin C.
// Assumes run, rev and one_ch are driven on the rising edge of clk.
`timescale 1ns/1ps
module ssis_sensor_model
(
	input wire logic clk,
	input wire logic run,
	input wire logic rev,
	input wire logic one_ch,
	output logic sa,
	output logic sb,
	output logic sc
);
	logic [1:0] ph_r = 2'h0;
	logic [1:0] div_r = 2'h0;
	logic [1:0] ph_nxt;
	logic sc_r = 1'b0;
	assign sc = sc_r;
	assign ph_nxt = rev ? ph_r - 2'h1 : ph_r + 2'h1;
	// Gray count keeps the two tracks a quarter period apart
	assign sa = ph_r[1];
	// One-track sensor leaves B idle low
	assign sb = one_ch ? 1'b0 : ph_r[1] ^ ph_r[0];
	always @(posedge clk)
	begin
		div_r <= run ? div_r + 2'h1 : 2'h0;
		if (run && div_r == 2'h3)
		begin
			ph_r <= ph_nxt;
			if (ph_nxt == 2'h0)
				sc_r <= ~sc_r;
		end
	end
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the speed sensor input stage.
// Assumes the sensor model owns the three pins; bench owns the bus.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] rdata;
	logic commutation_evt = 1'b0;
	logic run = 1'b0;
	logic rev = 1'b0;
	logic one_ch = 1'b0;
	logic sa, sb, sc, capture_evt, encoder_clk, dir, comp;
	logic [1:0] ma, mb, mc;
	logic [2:0] gnd, dig;
	int fail_count = 0;
	int tests_run = 0;
	int ncap, nenc;
	int cap_tot = 0;
	int enc_tot = 0;
	ssis_sensor_model ssis_sensor_model_inst (.clk(clk), .run(run),
		.rev(rev), .one_ch(one_ch), .sa(sa), .sb(sb), .sc(sc));
	ssis_top ssis_top_inst (.clk(clk), .nrst(nrst), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.commutation_evt(commutation_evt), .sensor_input_a(sa),
		.sensor_input_b(sb), .sensor_input_c(sc),
		.capture_evt(capture_evt), .encoder_clk(encoder_clk),
		.encoder_direction_flag(dir), .phase_comp_on(comp),
		.pin_mode_a(ma), .pin_mode_b(mb), .pin_mode_c(mc),
		.pin_ground(gnd), .dig_in_en(dig));
	initial
	begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		if (capture_evt === 1'b1)
			cap_tot++;
		if (encoder_clk === 1'b1)
			enc_tot++;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask
	task automatic modes(input logic [5:0] m, input logic c,
		input logic [2:0] d);
		#1;
		`CHK({ma, mb, mc}, m)
		`CHK(comp, c)
		`CHK(dig, d)
	endtask
	// n=64 gives sixteen steps: four periods on A and B, two on C
	// Counters are only read here, so the counting process owns them
	task automatic burst(input logic r, input logic o, input int n);
		int c0;
		int e0;
		@(posedge clk);
		c0 = cap_tot;
		e0 = enc_tot;
		run <= 1'b1;
		rev <= r;
		one_ch <= o;
		repeat (n) @(posedge clk);
		run <= 1'b0;
		repeat (10) @(posedge clk);
		ncap = cap_tot - c0;
		nenc = enc_tot - e0;
	endtask
	task automatic results;
		$display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		#1ms;
		fail_count++;
		results();
	end
	initial
	begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		modes(6'b01_11_11, 1'b1, 3'b000);
		`CHK(gnd, 3'b000)
		rd(ssis_pkg::CFG_ADDR, 8'h00);
		rd(ssis_pkg::STAT_ADDR, 8'h08);
		rd(4'hf, 8'h00);
		wr(ssis_pkg::CFG_ADDR, 8'h40);
		#1;
		`CHK(gnd, 3'b110)
		wr(ssis_pkg::CFG_ADDR, 8'ha4);
		modes(6'b00_01_00, 1'b1, 3'b101);
		wr(ssis_pkg::CFG_ADDR, 8'hac);
		modes(6'b00_00_00, 1'b0, 3'b111);
		// Software sets the select through the preload; commutation applies it
		wr(ssis_pkg::CFG_ADDR, 8'h01);
		wr(ssis_pkg::CFG_ADDR, 8'h09);
		rd(ssis_pkg::CFG_ADDR, 8'h01);
		@(posedge clk);
		commutation_evt <= 1'b1;
		@(posedge clk);
		commutation_evt <= 1'b0;
		rd(ssis_pkg::CFG_ADDR, 8'h09);
		// Preload write without direct access leaves the live select alone
		wr(ssis_pkg::PRE_ADDR, 8'h01);
		rd(ssis_pkg::PRE_ADDR, 8'h01);
		rd(ssis_pkg::CFG_ADDR, 8'h09);
		// Edge zero is only used to show that no events appear
		wr(ssis_pkg::CFG_ADDR, 8'h90);
		burst(1'b0, 1'b0, 64);
		`CHK(ncap, 0)
		for (int s = 0; s < 3; s++)
		begin
			for (int t = 1; t < 4; t++)
			begin
				wr(ssis_pkg::CFG_ADDR, 8'h90 | 8'(s << 2) | 8'(t));
				modes(6'b10_00_00 >> (2 * s), 1'b0, 3'b111);
				rd(ssis_pkg::STAT_ADDR, 8'h02);
				burst(1'b0, 1'b0, 64);
				`CHK(ncap, (s == 2 ? 2 : 4) * (t == 3 ? 2 : 1))
				`CHK(nenc, 0)
			end
		end
		wr(ssis_pkg::CFG_ADDR, 8'h9d);
		modes(6'b10_10_00, 1'b0, 3'b111);
		burst(1'b0, 1'b0, 64);
		`CHK(nenc, 16)
		`CHK(ncap, 0)
		`CHK(dir, 1'b1)
		wr(ssis_pkg::STAT_ADDR, 8'h00);
		rd(ssis_pkg::STAT_ADDR, 8'h07);
		burst(1'b1, 1'b0, 64);
		`CHK(nenc, 16)
		`CHK(dir, 1'b0)
		burst(1'b0, 1'b1, 64);
		`CHK(nenc, 8)
		// Comparator stays off when the edge field is cleared with encoder select
		wr(ssis_pkg::CFG_ADDR, 8'h9c);
		modes(6'b00_00_00, 1'b0, 3'b111);
		// Two steps leave A and B high and C low
		burst(1'b0, 1'b0, 8);
		rd(ssis_pkg::LVL_ADDR, 8'h03);
		// B turns analog, so its high level must vanish from the read
		wr(ssis_pkg::CFG_ADDR, 8'ha4);
		rd(ssis_pkg::LVL_ADDR, 8'h01);
		results();
	end
endmodule
